// File: alu_dsp_core.sv
module alu_dsp_core
    import alu_pkg::*;
(
    input wire logic CLK, // core clock
    input wire logic SYS_RST, // sync reset, high
    input wire alu_op_t ALU_OP, // integer operation
    input wire logic ALU_EN, // integer op strobe
    input wire logic BYTE_MODE, // byte-sized operation
    input wire logic SRC_MEM, // operand b from data memory
    input wire logic DST_MEM, // result to data memory
    input wire logic [15:0] WREG_A, // working register operand
    input wire logic [15:0] WREG_B, // working register operand b
    input wire logic [15:0] MEM_RDATA, // data memory operand
    input wire logic MUL_EN, // multiply strobe
    input wire mul_mode_t MUL_MODE, // multiply mode
    input wire logic [4:0] MUL_LIT, // unsigned literal
    input wire logic DIV_START, // divide start pulse
    input wire logic DIV_SIGNED, // signed divide
    input wire logic DIV_LONG, // 32-bit dividend
    input wire logic [15:0] DIV_HI, // odd register of pair
    input wire logic [15:0] DIV_LO, // even register of pair
    input wire logic [15:0] DIV_DIVISOR, // any working register
    input wire logic ENG_EN, // engine op strobe
    input wire acc_op_t ENG_OP, // engine operation
    input wire logic ENG_DST_B, // target second accumulator
    input wire logic [5:0] ENG_SHIFT, // signed shift, left positive
    input wire logic [15:0] ENG_X, // x operand
    input wire logic [15:0] ENG_Y, // y operand
    input wire logic ENG_STORE, // round and store accumulator
    input wire logic [15:0] CORE_CONTROL_WORD, // core control bits
    output logic [15:0] PROCESSOR_STATUS_WORD, // status flags
    output logic [15:0] WREG_WDATA, // result to registers
    output logic WREG_WE, // register write strobe
    output logic [1:0] WREG_BE, // register byte lanes
    output logic [15:0] MEM_WDATA, // result to memory
    output logic MEM_WE, // memory write strobe
    output logic [1:0] MEM_BE, // memory byte lanes
    output logic [31:0] MUL_RESULT, // product
    output logic MUL_VALID, // product strobe
    output logic [15:0] WORKING_REG_ZERO, // quotient
    output logic [15:0] WORKING_REG_ONE, // remainder
    output logic DIV_BUSY, // divider running
    output logic DIV_DONE, // results valid pulse
    output logic [39:0] FIRST_ACCUMULATOR, // accumulator a
    output logic [39:0] SECOND_ACCUMULATOR // accumulator b
);
    logic [15:0] status_reg; // status word
    logic [39:0] first_accumulator_reg; // first accumulator
    logic [39:0] second_accumulator_reg; // second accumulator
    logic [15:0] opb; // selected operand b
    logic [16:0] res; // result with carry
    logic [15:0] res16; // result kept
    logic c_f, z_f, n_f, ov_f, dc_f; // new flags
    logic msb_a, msb_b, msb_r; // size-dependent sign bits

    // operand source per addressing mode
    assign opb = SRC_MEM ? MEM_RDATA : WREG_B;

    // sign bit of a byte or word value
    function automatic logic sgn(input logic [15:0] v, input logic byt);
        sgn = byt ? v[7] : v[15];
    endfunction : sgn

    // integer unit
    always_comb begin
        res = 17'h0_0000;
        case (ALU_OP)
            OP_ADD: res = {1'b0, WREG_A} + {1'b0, opb};
            OP_ADC: res = {1'b0, WREG_A} + {1'b0, opb}
                + {16'h0000, status_reg[SW_C]};
            OP_SUB: res = {1'b0, WREG_A} + {1'b0, ~opb} + 17'h0_0001;
            OP_SBB: res = {1'b0, WREG_A} + {1'b0, ~opb}
                + {16'h0000, status_reg[SW_C]};
            OP_AND: res = {1'b0, WREG_A & opb};
            OP_OR: res = {1'b0, WREG_A | opb};
            OP_XOR: res = {1'b0, WREG_A ^ opb};
            OP_SHL: res = BYTE_MODE ? {8'h00, WREG_A[7:0], 1'b0}
                : {WREG_A, 1'b0};
            OP_LSR: res = BYTE_MODE ? {9'h000, 1'b0, WREG_A[7:1]}
                : {1'b0, 1'b0, WREG_A[15:1]};
            OP_ASR: res = BYTE_MODE ? {9'h000, WREG_A[7], WREG_A[7:1]}
                : {1'b0, WREG_A[15], WREG_A[15:1]};
            OP_PASS: res = {1'b0, opb};
            default: res = 17'h0_0000;
        endcase
        res16 = res[15:0];
        msb_a = sgn(WREG_A, BYTE_MODE);
        msb_b = sgn(opb, BYTE_MODE);
        msb_r = sgn(res16, BYTE_MODE);
        // carry out of bit 7 or 15; borrow shows as carry low
        c_f = BYTE_MODE ? (ALU_OP == OP_SHL ? WREG_A[7]
            : (ALU_OP inside {OP_LSR, OP_ASR}) ? WREG_A[0]
            : ({1'b0, WREG_A[7:0]} + {1'b0, (ALU_OP inside {OP_SUB,
              OP_SBB}) ? ~opb[7:0] : opb[7:0]}
              + {8'h00, (ALU_OP == OP_SUB) | ((ALU_OP inside {OP_ADC,
              OP_SBB}) & status_reg[SW_C])}) > 9'h0FF)
            : ((ALU_OP inside {OP_LSR, OP_ASR}) ? WREG_A[0] : res[16]);
        // digit carry from bit 3 (byte) or bit 7 (word)
        dc_f = BYTE_MODE ? (res16[4] ^ WREG_A[4]
            ^ ((ALU_OP inside {OP_SUB, OP_SBB}) ? ~opb[4] : opb[4]))
            : (res16[8] ^ WREG_A[8]
            ^ ((ALU_OP inside {OP_SUB, OP_SBB}) ? ~opb[8] : opb[8]));
        z_f = BYTE_MODE ? (res16[7:0] == 8'h00) : (res16 == 16'h0000);
        n_f = msb_r;
        ov_f = (ALU_OP inside {OP_ADD, OP_ADC})
            ? (msb_a == msb_b) & (msb_r != msb_a)
            : (ALU_OP inside {OP_SUB, OP_SBB})
            ? (msb_a != msb_b) & (msb_r != msb_a)
            : (ALU_OP inside {OP_SHL}) ? (msb_r != msb_a) : 1'b0;
    end

    // status flag updates per operation class
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            status_reg <= STATUS_RESET;
        end else if (ALU_EN) begin
            status_reg[SW_N] <= n_f;
            status_reg[SW_Z] <= z_f;
            // logic ops leave carry, overflow, digit carry alone
            if (!(ALU_OP inside {OP_AND, OP_OR, OP_XOR, OP_PASS})) begin
                status_reg[SW_C] <= c_f;
                status_reg[SW_OV] <= ov_f;
            end
            if (ALU_OP inside {OP_ADD, OP_ADC, OP_SUB, OP_SBB}) begin
                status_reg[SW_DC] <= dc_f;
            end
        end
    end

    // write-back to register or memory with byte lanes
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WREG_WDATA <= 16'h0000;
            WREG_WE <= 1'b0;
            WREG_BE <= 2'h0;
            MEM_WE <= 1'b0;
            MEM_BE <= 2'h0;
        end else begin
            WREG_WE <= ALU_EN & ~DST_MEM;
            MEM_WE <= ALU_EN & DST_MEM;
            WREG_BE <= BYTE_MODE ? 2'h1 : 2'h3;
            MEM_BE <= BYTE_MODE ? 2'h1 : 2'h3;
            if (ALU_EN) WREG_WDATA <= res16;
        end
    end

    // general multiply: operands widened to 17 bits by mode
    logic [16:0] ma, mb; // 17-bit operands
    logic signed [33:0] prod; // signed 17x17 product
    always_comb begin
        ma = {1'b0, WREG_A};
        mb = {1'b0, opb};
        case (MUL_MODE)
            MUL_SS: {ma, mb} = {WREG_A[15], WREG_A, opb[15], opb};
            MUL_UU: {ma, mb} = {1'b0, WREG_A, 1'b0, opb};
            MUL_SU: {ma, mb} = {WREG_A[15], WREG_A, 1'b0, opb};
            MUL_US: {ma, mb} = {1'b0, WREG_A, opb[15], opb};
            MUL_SLIT: {ma, mb} = {WREG_A[15], WREG_A, 12'h000, MUL_LIT};
            MUL_ULIT: {ma, mb} = {1'b0, WREG_A, 12'h000, MUL_LIT};
            MUL_BYTE: {ma, mb} = {9'h000, WREG_A[7:0], 9'h000, opb[7:0]};
            default: {ma, mb} = {1'b0, WREG_A, 1'b0, opb};
        endcase
    end
    assign prod = $signed(ma) * $signed(mb);

    // product register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MUL_RESULT <= 32'h0000_0000;
            MUL_VALID <= 1'b0;
        end else begin
            MUL_VALID <= MUL_EN;
            if (MUL_EN) MUL_RESULT <= prod[31:0];
        end
    end

    // divider: even pair, high register holds upper half
    iter_divider u_div (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .START(DIV_START),
        .SIGNED_DIV(DIV_SIGNED),
        .LONG_DIV(DIV_LONG),
        .DIVIDEND({DIV_HI, DIV_LO}),
        .DIVISOR(DIV_DIVISOR),
        .BUSY(DIV_BUSY),
        .DONE(DIV_DONE),
        .QUOTIENT(WORKING_REG_ZERO),
        .REMAINDER(WORKING_REG_ONE)
    );

    // engine multiply per signedness and format
    logic [1:0] us_f; // signedness field
    logic [16:0] ex, ey; // engine operands
    logic signed [33:0] eprod; // engine product
    logic [39:0] eprod40; // product aligned into accumulator
    assign us_f = CORE_CONTROL_WORD[CC_US_LO +: 2];
    always_comb begin
        ex = {ENG_X[15], ENG_X};
        ey = {ENG_Y[15], ENG_Y};
        if (us_f == US_UNSIGNED) begin
            ex = {1'b0, ENG_X};
            ey = {1'b0, ENG_Y};
        end else if (us_f == US_MIXED) begin
            ey = {1'b0, ENG_Y}; // y taken unsigned
        end
    end
    assign eprod = $signed(ex) * $signed(ey);
    // fractional mode shifts left one
    assign eprod40 = CORE_CONTROL_WORD[CC_IF] ? {{6{eprod[33]}}, eprod}
        : {{5{eprod[33]}}, eprod, 1'b0};

    // saturation against the selected limit
    function automatic logic [39:0] sat40(input logic [40:0] v,
                                          input logic en,
                                          input logic super_m);
        logic [40:0] pl, nl;
        pl = super_m ? {1'b0, SAT_POS_SUPER} : {1'b0, SAT_POS_NORM};
        nl = super_m ? {1'b1, SAT_NEG_SUPER} : {1'b1, SAT_NEG_NORM};
        if (!en) sat40 = v[39:0];
        else if (!v[40] && v > pl) sat40 = pl[39:0];
        else if (v[40] && $signed(v) < $signed(nl)) sat40 = nl[39:0];
        else sat40 = v[39:0];
    endfunction : sat40

    // barrel shifter and adder for the target accumulator
    logic [39:0] acc_t, acc_o, shv; // target, other, shifted other
    logic [40:0] sum; // 41-bit adder output
    assign acc_t = ENG_DST_B ? second_accumulator_reg : first_accumulator_reg;
    assign acc_o = ENG_DST_B ? first_accumulator_reg : second_accumulator_reg;
    assign shv = ENG_SHIFT[5] ? 40'($signed(acc_o) >>> 6'(-ENG_SHIFT))
        : (acc_o << ENG_SHIFT);
    always_comb begin
        case (ENG_OP)
            ACC_MAC: sum = {acc_t[39], acc_t} + {eprod40[39], eprod40};
            ACC_MSC: sum = {acc_t[39], acc_t} - {eprod40[39], eprod40};
            ACC_MPY: sum = {eprod40[39], eprod40};
            ACC_ADD: sum = {acc_t[39], acc_t} + {shv[39], shv};
            ACC_SUB: sum = {acc_t[39], acc_t} - {shv[39], shv};
            ACC_NEG: sum = 41'h000_0000_0000 - {acc_t[39], acc_t};
            ACC_CLR: sum = 41'h000_0000_0000;
            default: sum = {acc_t[39], acc_t};
        endcase
    end

    // accumulator update with per-target saturation enable
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            first_accumulator_reg <= ACC_RESET;
            second_accumulator_reg <= ACC_RESET;
        end else if (ENG_EN && ENG_OP != ACC_NOP) begin
            if (ENG_DST_B)
                second_accumulator_reg <= sat40(sum, CORE_CONTROL_WORD[CC_SECOND_ACCUM_SATURATE_ENABLE],
                    CORE_CONTROL_WORD[CC_SATMODE]);
            else
                first_accumulator_reg <= sat40(sum, CORE_CONTROL_WORD[CC_FIRST_ACCUM_SATURATE_ENABLE],
                    CORE_CONTROL_WORD[CC_SATMODE]);
        end
    end

    // rounded store of accumulator high word to memory
    logic [39:0] rnd; // rounded accumulator
    logic [15:0] stw; // saturated store word
    always_comb begin
        // conventional adds half; convergent ties round to even
        if (CORE_CONTROL_WORD[CC_RND] || acc_t[15:0] != 16'h8000)
            rnd = acc_t + 40'h00_0000_8000;
        else
            rnd = acc_t + {23'h00_0000, acc_t[16], 16'h0000};
        if (CORE_CONTROL_WORD[CC_MEMORY_WRITE_SATURATE_ENABLE] && rnd[39:31] != {9{rnd[39]}})
            stw = rnd[39] ? 16'h8000 : 16'h7FFF;
        else
            stw = rnd[31:16];
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) MEM_WDATA <= 16'h0000;
        else if (ENG_STORE) MEM_WDATA <= stw;
        else if (ALU_EN && DST_MEM) MEM_WDATA <= res16;
    end

    assign PROCESSOR_STATUS_WORD = status_reg;
    assign FIRST_ACCUMULATOR = first_accumulator_reg;
    assign SECOND_ACCUMULATOR = second_accumulator_reg;
endmodule : alu_dsp_core

// File: alu_dsp_core_asserts.sv
module alu_dsp_core_asserts
    import alu_pkg::*;
(
    input wire logic CLK, // core clock
    input wire logic SYS_RST, // sync reset
    input wire logic ALU_EN, // alu strobe
    input wire logic BYTE_MODE, // byte op
    input wire logic DST_MEM, // result to memory
    input wire logic WREG_WE, // reg write
    input wire logic [1:0] WREG_BE, // reg lanes
    input wire logic MEM_WE, // memory write
    input wire logic MUL_EN, // mul strobe
    input wire logic MUL_VALID, // product strobe
    input wire logic DIV_START, // divide start
    input wire logic DIV_BUSY, // divider running
    input wire logic DIV_DONE, // divide done
    input wire logic ENG_EN, // engine strobe
    input wire acc_op_t ENG_OP, // engine op
    input wire logic ENG_DST_B, // second acc target
    input wire logic [15:0] CORE_CONTROL_WORD, // control bits
    input wire logic [39:0] FIRST_ACCUMULATOR // first acc
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // sixteen busy cycles, then the done pulse
    sequence div_run_s;
        DIV_BUSY [*8] ##1 DIV_BUSY [*8] ##1 DIV_DONE;
    endsequence
    mem_dest_a: assert property (
        ALU_EN && DST_MEM |=> MEM_WE && !WREG_WE) else $error("mem dest");
    byte_lane_a: assert property (
        ALU_EN && !DST_MEM |=> WREG_WE && !MEM_WE &&
        WREG_BE == ($past(BYTE_MODE) ? 2'h1 : 2'h3)) else $error("lanes");
    mul_valid_a: assert property (
        MUL_EN |=> MUL_VALID) else $error("no product");
    div_len_a: assert property (
        DIV_START && !DIV_BUSY && !DIV_DONE |=> div_run_s)
        else $error("divide length");
    acc_hold_a: assert property (
        !ENG_EN |=> $stable(FIRST_ACCUMULATOR)) else $error("acc moved");
    acc_clr_a: assert property (
        ENG_EN && ENG_OP == ACC_CLR && !ENG_DST_B |=>
        FIRST_ACCUMULATOR == 40'h0) else $error("clear");
    acc_neg_a: assert property (
        ENG_EN && ENG_OP == ACC_NEG && !ENG_DST_B &&
        CORE_CONTROL_WORD[7:4] == 4'h0 |=> FIRST_ACCUMULATOR ==
        40'h0 - $past(FIRST_ACCUMULATOR)) else $error("negate");
    sat_norm_a: assert property (
        ENG_EN && !ENG_DST_B && CORE_CONTROL_WORD[7:4] == 4'h8 |=>
        $signed(FIRST_ACCUMULATOR) <= $signed(40'h00_7FFF_FFFF) &&
        $signed(FIRST_ACCUMULATOR) >= $signed(40'hFF_8000_0000))
        else $error("saturation");
endmodule : alu_dsp_core_asserts
bind alu_dsp_core alu_dsp_core_asserts chk (.*);

// File: alu_pkg.sv
package alu_pkg;
    // integer unit operations
    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3,
        OP_XOR = 4'h4, OP_SHL = 4'h5, OP_LSR = 4'h6, OP_ASR = 4'h7,
        OP_ADC = 4'h8, OP_SBB = 4'h9, OP_PASS = 4'hA
    } alu_op_t;
    // multiply modes
    typedef enum logic [2:0] {
        MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_SU = 3'h2, MUL_US = 3'h3,
        MUL_SLIT = 3'h4, MUL_ULIT = 3'h5, MUL_BYTE = 3'h6
    } mul_mode_t;
    // accumulator operations
    typedef enum logic [2:0] {
        ACC_NOP = 3'h0, ACC_MAC = 3'h1, ACC_MSC = 3'h2, ACC_MPY = 3'h3,
        ACC_ADD = 3'h4, ACC_SUB = 3'h5, ACC_NEG = 3'h6, ACC_CLR = 3'h7
    } acc_op_t;
    // divider states, gray along idle-run-done
    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00, DIV_RUN = 2'b01, DIV_DONE = 2'b11
    } div_state_t;
    // status word bit positions
    localparam int SW_C = 0;
    localparam int SW_Z = 1;
    localparam int SW_OV = 2;
    localparam int SW_N = 3;
    localparam int SW_DC = 8;
    // core control bit positions
    localparam int CC_IF = 0;
    localparam int CC_RND = 1;
    localparam int CC_SATMODE = 4;
    localparam int CC_MEMORY_WRITE_SATURATE_ENABLE = 5;
    localparam int CC_SECOND_ACCUM_SATURATE_ENABLE = 6;
    localparam int CC_FIRST_ACCUM_SATURATE_ENABLE = 7;
    localparam int CC_US_LO = 12;
    // signedness field encodings
    localparam logic [1:0] US_SIGNED = 2'h0;
    localparam logic [1:0] US_UNSIGNED = 2'h1;
    localparam logic [1:0] US_MIXED = 2'h2;
    // divider iterations, one per divisor bit
    localparam logic [4:0] DIV_CYCLES = 5'h10;
    // reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
    // saturation limits: normal 1.31 and super 9.31
    localparam logic [39:0] SAT_POS_NORM = 40'h00_7FFF_FFFF;
    localparam logic [39:0] SAT_NEG_NORM = 40'hFF_8000_0000;
    localparam logic [39:0] SAT_POS_SUPER = 40'h7F_FFFF_FFFF;
    localparam logic [39:0] SAT_NEG_SUPER = 40'h80_0000_0000;
endpackage : alu_pkg

// File: data_mem_model.sv
module data_mem_model (
    input wire logic CLK, // core clock
    input wire logic MEM_WE, // write strobe
    input wire logic [1:0] MEM_BE, // byte lanes
    input wire logic [15:0] MEM_WDATA, // write data
    output logic [15:0] MEM_RDATA // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial MEM_RDATA = 16'h0000;
    // one memory word, written lane by lane
    always @(posedge CLK) begin
        if (MEM_WE && MEM_BE[0]) MEM_RDATA[7:0] <= MEM_WDATA[7:0];
        if (MEM_WE && MEM_BE[1]) MEM_RDATA[15:8] <= MEM_WDATA[15:8];
    end
endmodule : data_mem_model

// File: iter_divider.sv
module iter_divider
    import alu_pkg::*;
(
    input wire logic CLK, // core clock
    input wire logic SYS_RST, // sync reset, high
    input wire logic START, // one-cycle start pulse
    input wire logic SIGNED_DIV, // signed operands
    input wire logic LONG_DIV, // 32-bit dividend
    input wire logic [31:0] DIVIDEND, // dividend word pair
    input wire logic [15:0] DIVISOR, // divisor
    output logic BUSY, // division running
    output logic DONE, // one-cycle result pulse
    output logic [15:0] QUOTIENT, // quotient
    output logic [15:0] REMAINDER // remainder
);
    div_state_t state_reg; // sequencer state
    logic [4:0] count_reg; // iterations left
    logic [31:0] rq_reg; // quotient bits shifted in
    logic [16:0] rem_reg; // partial remainder
    logic [15:0] dvs_reg; // divisor magnitude
    logic qneg_reg; // negate quotient at end
    logic rneg_reg; // negate remainder at end
    logic [31:0] dmag; // dividend magnitude
    logic [16:0] trial; // trial subtract
    logic [16:0] shifted; // remainder shifted left

    // magnitude of dividend, sign-extending the short form for signed divides, zero-extending it otherwise
    always_comb begin
        logic [31:0] ext;
        ext = LONG_DIV ? DIVIDEND
            : {{16{SIGNED_DIV & DIVIDEND[15]}}, DIVIDEND[15:0]};
        dmag = (SIGNED_DIV && ext[31]) ? 32'(-ext) : ext;
    end

    // restoring step on the top bits
    assign shifted = {rem_reg[15:0], rq_reg[31]};
    assign trial = shifted - {1'b0, dvs_reg};

    // sequencer: sixteen steps regardless of dividend length
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= DIV_IDLE;
            count_reg <= 5'h00;
        end else begin
            case (state_reg)
                DIV_IDLE: begin
                    if (START) begin
                        state_reg <= DIV_RUN;
                        count_reg <= DIV_CYCLES;
                    end
                end
                DIV_RUN: begin
                    count_reg <= count_reg - 5'h01;
                    if (count_reg == 5'h01) state_reg <= DIV_DONE;
                end
                DIV_DONE: state_reg <= DIV_IDLE;
                default: state_reg <= DIV_IDLE;
            endcase
        end
    end

    // datapath: load, then one quotient bit per cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rq_reg <= 32'h0000_0000;
            rem_reg <= 17'h0_0000;
            dvs_reg <= 16'h0000;
            qneg_reg <= 1'b0;
            rneg_reg <= 1'b0;
        end else if (state_reg == DIV_IDLE && START) begin
            // upper half seeds the remainder, lower half gets shifted
            rem_reg <= {1'b0, dmag[31:16]};
            rq_reg <= {dmag[15:0], 16'h0000};
            dvs_reg <= (SIGNED_DIV && DIVISOR[15]) ? 16'(-DIVISOR) : DIVISOR;
            qneg_reg <= SIGNED_DIV & (DIVIDEND[LONG_DIV ? 31 : 15]
                ^ DIVISOR[15]);
            rneg_reg <= SIGNED_DIV & DIVIDEND[LONG_DIV ? 31 : 15];
        end else if (state_reg == DIV_RUN) begin
            if (!trial[16]) begin
                rem_reg <= trial;
                rq_reg <= {rq_reg[30:0], 1'b1};
            end else begin
                rem_reg <= shifted;
                rq_reg <= {rq_reg[30:0], 1'b0};
            end
        end
    end

    // results registered on completion
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            QUOTIENT <= 16'h0000;
            REMAINDER <= 16'h0000;
        end else if (state_reg == DIV_RUN && count_reg == 5'h01) begin
            QUOTIENT <= qneg_reg ? 16'(-(trial[16] ? {rq_reg[14:0], 1'b0}
                : {rq_reg[14:0], 1'b1}))
                : (trial[16] ? {rq_reg[14:0], 1'b0} : {rq_reg[14:0], 1'b1});
            REMAINDER <= rneg_reg ? 16'(-(trial[16] ? shifted[15:0]
                : trial[15:0])) : (trial[16] ? shifted[15:0] : trial[15:0]);
        end
    end

    assign BUSY = (state_reg == DIV_RUN);
    assign DONE = (state_reg == DIV_DONE);
endmodule : iter_divider

// File: test_cpu_alu_mul_div_dsp_engine.sv
module test_cpu_alu_mul_div_dsp_engine
    import alu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, SYS_RST, ALU_EN, BYTE_MODE, SRC_MEM, DST_MEM, MUL_EN, MEM_WE;
    logic DIV_START, DIV_SIGNED, DIV_LONG, ENG_EN, ENG_DST_B, ENG_STORE;
    logic WREG_WE, MUL_VALID, DIV_BUSY, DIV_DONE;
    logic [1:0] WREG_BE, MEM_BE;
    logic [4:0] MUL_LIT;
    logic [5:0] ENG_SHIFT;
    logic [15:0] WREG_A, WREG_B, MEM_RDATA, DIV_HI, DIV_LO, DIV_DIVISOR;
    logic [15:0] ENG_X, ENG_Y, CORE_CONTROL_WORD, PROCESSOR_STATUS_WORD;
    logic [15:0] WREG_WDATA, MEM_WDATA, WORKING_REG_ZERO, WORKING_REG_ONE;
    logic [31:0] MUL_RESULT;
    logic [39:0] FIRST_ACCUMULATOR, SECOND_ACCUMULATOR;
    alu_op_t ALU_OP;
    mul_mode_t MUL_MODE;
    acc_op_t ENG_OP;
    int error_cnt = 0;
    int check_count = 0;
    alu_dsp_core uut (.*);
    data_mem_model mem (.*);
    always #2.5 CLK = ~CLK;
    task chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // one engine op with x equal to y, then a settle cycle
    task eng(input acc_op_t op, input logic dst, input logic [15:0] x);
        {ENG_OP, ENG_DST_B, ENG_X, ENG_Y, ENG_EN} = {op, dst, x, x, 1'b1};
        @(negedge CLK);
        ENG_EN = 1'b0;
        @(negedge CLK);
    endtask : eng
    initial begin
        int a, b, r, w, m, k, c;
        longint p, d;
        logic [15:0] mv;
        logic [31:0] pr;
        logic [39:0] e;
        {CLK, SYS_RST, ALU_EN, BYTE_MODE, SRC_MEM, DST_MEM, MUL_EN} = 7'h20;
        {DIV_START, DIV_SIGNED, DIV_LONG, ENG_EN, ENG_DST_B, ENG_STORE} = '0;
        {MUL_LIT, ENG_SHIFT, WREG_A, WREG_B, DIV_HI, DIV_LO} = '0;
        {DIV_DIVISOR, ENG_X, ENG_Y, CORE_CONTROL_WORD, mv} = '0;
        {ALU_OP, MUL_MODE, ENG_OP} = {OP_ADD, MUL_SS, ACC_NOP};
        void'($urandom(65530));
        repeat (5) @(negedge CLK);
        SYS_RST = 1'b0;
        // add and subtract, byte and word, register and memory
        for (int i = 0; i < 32; i++) begin
            ALU_OP = i[0] ? OP_SUB : OP_ADD;
            {DST_MEM, SRC_MEM, BYTE_MODE} = i[3:1];
            {WREG_A, WREG_B, ALU_EN} = {16'($urandom), 16'($urandom), 1'b1};
            w = BYTE_MODE ? 8 : 16;
            m = (1 << w) - 1;
            k = w / 2;
            c = i % 2;
            a = WREG_A & m;
            b = ((SRC_MEM ? mv : WREG_B) ^ (c ? m : 0)) & m;
            r = a + b + c;
            e = 40'h0;
            e[0] = r[w];
            e[1] = (r & m) == 0;
            e[2] = a[w-1] == b[w-1] && r[w-1] != a[w-1];
            e[3] = r[w-1];
            e[8] = ((a & (m >> k)) + (b & (m >> k)) + c) >> k;
            @(negedge CLK);
            ALU_EN = 1'b0;
            chk((DST_MEM ? MEM_WDATA : WREG_WDATA) & m, r & m);
            chk(PROCESSOR_STATUS_WORD & 16'h010F, e);
            chk({DST_MEM ? MEM_BE : WREG_BE, WREG_WE, MEM_WE},
                {BYTE_MODE ? 2'h1 : 2'h3, !DST_MEM, DST_MEM});
            if (DST_MEM) mv = (mv & ~16'(m)) | 16'(r & m);
            @(negedge CLK);
        end
        {DST_MEM, SRC_MEM, BYTE_MODE} = 3'h0;
        // logic ops and shifts, word size: result, negative and zero
        for (int i = 0; i < 12; i++) begin
            k = i % 6;
            ALU_OP = alu_op_t'(k + 2);
            {WREG_A, WREG_B, ALU_EN} = {16'($urandom), 16'($urandom), 1'b1};
            r = k == 0 ? WREG_A & WREG_B : k == 1 ? WREG_A | WREG_B
                : k == 2 ? WREG_A ^ WREG_B : k == 3 ? WREG_A << 1
                : k == 4 ? WREG_A >> 1 : {WREG_A[15], WREG_A[15:1]};
            @(negedge CLK);
            ALU_EN = 1'b0;
            chk({WREG_WDATA, PROCESSOR_STATUS_WORD[3],
                PROCESSOR_STATUS_WORD[1]},
                {16'(r), r[15], 16'(r) == 0});
            @(negedge CLK);
        end
        // every multiply mode, three times each
        for (int i = 0; i < 21; i++) begin
            MUL_MODE = mul_mode_t'(i % 7);
            {WREG_A, WREG_B, MUL_LIT} = {16'($urandom), 16'($urandom), 5'($urandom)};
            MUL_EN = 1'b1;
            {a, b} = {32'(WREG_A), 32'(WREG_B)};
            if (i % 7 inside {0, 2, 4}) a = $signed(WREG_A);
            if (i % 7 inside {0, 3}) b = $signed(WREG_B);
            if (i % 7 inside {4, 5}) b = MUL_LIT;
            if (i % 7 == 6) {a, b} = {24'h0, WREG_A[7:0], 24'h0, WREG_B[7:0]};
            pr = a * b;
            @(negedge CLK);
            MUL_EN = 1'b0;
            chk({MUL_VALID, MUL_RESULT}, {1'b1, pr});
            @(negedge CLK);
        end
        // long and short, signed and unsigned division
        for (int i = 0; i < 16; i++) begin
            {DIV_LONG, DIV_SIGNED} = i[1:0];
            {DIV_DIVISOR, DIV_LO} = {16'($urandom_range(16'hFFFE, 2)), 16'($urandom)};
            DIV_HI = DIV_SIGNED ? {16{DIV_LO[15]}} : 16'($urandom_range(DIV_DIVISOR - 1, 0));
            {p, d} = {32'h0, DIV_LONG ? {DIV_HI, DIV_LO} : {16'h0, DIV_LO},
                48'h0, DIV_DIVISOR};
            if (DIV_SIGNED) begin
                p = DIV_LONG ? $signed({DIV_HI, DIV_LO}) : $signed(DIV_LO);
                d = $signed(DIV_DIVISOR);
            end
            DIV_START = 1'b1;
            @(negedge CLK);
            DIV_START = 1'b0;
            k = 0;
            while (DIV_DONE !== 1'b1 && k < 40) begin
                @(negedge CLK);
                k++;
            end
            if (k == 40) begin
                error_cnt++;
                wrap_up;
            end
            chk(k, 16);
            chk({WORKING_REG_ZERO, WORKING_REG_ONE}, {16'(p / d), 16'(p % d)});
            @(negedge CLK);
        end
        d = 0;
        // signedness field in integer mode, reserved code included
        for (int i = 0; i < 4; i++) begin
            CORE_CONTROL_WORD = {2'h0, i[1:0], 12'h001};
            eng(ACC_MPY, 1'b0, 16'hFFFF);
            e = i == 1 ? 40'h00_FFFE_0001 : i == 2 ? 40'hFF_FFFF_0001 : 40'h1;
            chk(FIRST_ACCUMULATOR, e);
            eng(i[0] ? ACC_MSC : ACC_MAC, 1'b1, 16'hFFFF);
            d = i[0] ? d - $signed(e) : d + $signed(e);
            chk(SECOND_ACCUMULATOR, 40'(d));
        end
        // fractional sum with saturation off, normal and super
        for (int i = 0; i < 3; i++) begin
            CORE_CONTROL_WORD = i == 0 ? 16'h0000 : i == 1 ? 16'h0080
                : 16'h00B0;
            eng(ACC_MPY, 1'b0, 16'h7FFF);
            eng(ACC_MPY, 1'b1, 16'h7FFF);
            chk(SECOND_ACCUMULATOR, 40'h00_7FFE_0002);
            eng(ACC_ADD, 1'b0, 16'h0000);
            e = i == 1 ? 40'h00_7FFF_FFFF : 40'h00_FFFC_0004;
            chk(FIRST_ACCUMULATOR, e);
            // rounded store of the high word, saturated on the last pass
            ENG_STORE = 1'b1;
            @(negedge CLK);
            ENG_STORE = 1'b0;
            w = i == 0 ? 16'hFFFC : i == 1 ? 16'h8000 : 16'h7FFF;
            chk(MEM_WDATA, w);
            eng(ACC_NEG, 1'b0, 16'h0000);
            chk(FIRST_ACCUMULATOR, 40'h0 - e);
            eng(ACC_CLR, 1'b0, 16'h0000);
            chk(FIRST_ACCUMULATOR, 40'h0);
        end
        wrap_up;
    end
endmodule : test_cpu_alu_mul_div_dsp_engine
